//--- rtl/tlip_top.sv
// Two-level interrupt prioritizer with its special function registers.
// Behaviour
// - Priority register bits 6..0 set source levels.
// - Secondary bits 6,5,4 set interval/supply/SPI levels.
// - Secondary bits 2,1,0 enable interval/supply/SPI.
// - Secondary resets A0H, priority resets 00H.
// - High request preempts a low routine.
// - Simultaneous levels: high request vectored first.
// - Same level never preempts running routine.
// - Same-level requests follow fixed polling order.
// - Accept: push program counter, load vector.
// - Vectors 0003H through 002BH for classic sources.
// - Vectors 0033H through 005BH for added sources.
// - Main enable bit 7 is global enable.
// - Main enable bits 5..0 enable classic sources, bit 6 the ADC.
`timescale 1ns/10ps
`default_nettype none
module tlip_top (
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  input  wire logic                  clkEn,
  input  wire tlip_pkg::tlip_sfr_req_t sfrReq,
  output logic [7:0]                 sfrRdData,
  output logic                       sfrHit,
  input  wire logic                  supply_mon_irq,
  input  wire logic                  watchdog_irq,
  input  wire logic                  ext0_irq,
  input  wire logic                  adc_irq,
  input  wire logic                  timer0_irq,
  input  wire logic                  ext1_irq,
  input  wire logic                  timer1_irq,
  input  wire logic                  spi_i2c_irq,
  input  wire logic                  uart_irq,
  input  wire logic                  timer2_irq,
  input  wire logic                  interval_irq,
  output logic                       vecReq,
  output var tlip_pkg::tlip_vec_t    vecOut,
  input  wire logic                  vecAck,
  input  wire logic                  retiDone,
  output logic                       lowActive,
  output logic                       highActive
);

  localparam int N = tlip_pkg::NUM_SRC;

  logic       rstMeta_q;   // First reset release stage.
  logic       rstSync_q;   // Synchronised reset used by the design.
  logic [7:0] mainEn_q;    // Main enable register.
  logic [7:0] prioPri_q;   // Primary priority register.
  logic [7:0] secCtrl_q;   // Secondary control register.
  logic [N-1:0] reqMeta_q; // First synchroniser stage of request pins.
  logic [N-1:0] req_q;     // Synchronised requests.
  logic [N-1:0] srcEn;     // Per-source enable, polling order.
  logic [N-1:0] srcHigh;   // Per-source high level, polling order.
  logic [N-1:0] pendHigh;  // Enabled high-level requests.
  logic [N-1:0] pendLow;   // Enabled low-level requests.
  logic       anyHigh;     // Some high request pending.
  logic       anyLow;      // Some low request pending.
  logic [3:0] idxHigh;     // First high request in polling order.
  logic [3:0] idxLow;      // First low request in polling order.
  logic       canHigh;     // A high request may be accepted now.
  logic       canLow;      // A low request may be accepted now.
  logic       vecValid_q;  // Vector request is offered to the core.
  tlip_pkg::tlip_vec_t vec_q; // Vector held for the core.
  logic       takeHigh;    // Core accepts a high vector.
  logic       takeLow;     // Core accepts a low vector.

  // Vector lookup for a polling-order index.
  function automatic logic [15:0] vecOf(input logic [3:0] s);
    case (s)
      4'h0:    vecOf = tlip_pkg::VEC_SUPPLY;
      4'h1:    vecOf = tlip_pkg::VEC_WATCHDOG;
      4'h2:    vecOf = tlip_pkg::VEC_EXT0;
      4'h3:    vecOf = tlip_pkg::VEC_ADC;
      4'h4:    vecOf = tlip_pkg::VEC_TIMER0;
      4'h5:    vecOf = tlip_pkg::VEC_EXT1;
      4'h6:    vecOf = tlip_pkg::VEC_TIMER1;
      4'h7:    vecOf = tlip_pkg::VEC_SPI;
      4'h8:    vecOf = tlip_pkg::VEC_UART;
      4'h9:    vecOf = tlip_pkg::VEC_TIMER2;
      4'hA:    vecOf = tlip_pkg::VEC_INTERVAL;
      default: vecOf = tlip_pkg::VEC_WATCHDOG;
    endcase
  endfunction

  // Reset release goes through two flops so all state leaves reset together.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end

  // Request pins come from other logic clocks, so each passes two flops.
  always_ff @(posedge mclk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      reqMeta_q <= '0;
      req_q     <= '0;
    end else if (clkEn) begin
      reqMeta_q <= {interval_irq, timer2_irq, uart_irq, spi_i2c_irq, timer1_irq, ext1_irq,
                    timer0_irq, adc_irq, ext0_irq, watchdog_irq, supply_mon_irq};
      req_q     <= reqMeta_q;
    end
  end

  // Register writes; priority bit 7 stores zero, secondary bit 7 keeps its reset value and bit 3 is stored as written.
  always_ff @(posedge mclk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      mainEn_q  <= tlip_pkg::MAIN_EN_RESET;
      prioPri_q <= tlip_pkg::PRIO_PRI_RESET;
      secCtrl_q <= tlip_pkg::SEC_CTRL_RESET;
    end else if (clkEn && sfrReq.wrEn) begin
      case (sfrReq.addr)
        tlip_pkg::MAIN_EN_ADDR: begin
          mainEn_q <= sfrReq.wrData;
        end
        tlip_pkg::PRIO_PRI_ADDR: begin
          prioPri_q <= {1'b0, sfrReq.wrData[6:0]};
        end
        tlip_pkg::SEC_CTRL_ADDR: begin
          // Bit 7 keeps its reset value; bit 3 is stored as written, software keeps it 0.
          secCtrl_q <= {secCtrl_q[7], sfrReq.wrData[6:0]};
        end
        default: begin
        end
      endcase
    end
  end

  // Register reads are combinational so the core sees data in the request cycle.
  always_comb begin
    sfrHit    = sfrReq.rdEn;
    sfrRdData = 8'h00;
    case (sfrReq.addr)
      tlip_pkg::MAIN_EN_ADDR:  sfrRdData = mainEn_q;
      tlip_pkg::PRIO_PRI_ADDR: sfrRdData = prioPri_q;
      tlip_pkg::SEC_CTRL_ADDR: sfrRdData = secCtrl_q;
      default:                 sfrHit    = 1'b0;
    endcase
    if (!sfrReq.rdEn) begin
      sfrRdData = 8'h00;
    end
  end

  // Map enables and levels into polling order; the watchdog is always enabled.
  always_comb begin
    srcEn  = '0;
    srcHigh = '0;
    srcEn[tlip_pkg::SRC_SUPPLY]   = secCtrl_q[tlip_pkg::SEC_SUPPLY_EN];
    srcEn[tlip_pkg::SRC_WATCHDOG] = 1'b1;
    srcEn[tlip_pkg::SRC_EXT0]     = mainEn_q[0];
    srcEn[tlip_pkg::SRC_ADC]      = mainEn_q[6];
    srcEn[tlip_pkg::SRC_TIMER0]   = mainEn_q[1];
    srcEn[tlip_pkg::SRC_EXT1]     = mainEn_q[2];
    srcEn[tlip_pkg::SRC_TIMER1]   = mainEn_q[3];
    srcEn[tlip_pkg::SRC_SPI]      = secCtrl_q[tlip_pkg::SEC_SPI_EN];
    srcEn[tlip_pkg::SRC_UART]     = mainEn_q[4];
    srcEn[tlip_pkg::SRC_TIMER2]   = mainEn_q[5];
    srcEn[tlip_pkg::SRC_INTERVAL] = secCtrl_q[tlip_pkg::SEC_INTERVAL_EN];
    srcHigh[tlip_pkg::SRC_SUPPLY]   = secCtrl_q[tlip_pkg::SEC_SUPPLY_PRIO];
    srcHigh[tlip_pkg::SRC_WATCHDOG] = 1'b0;
    srcHigh[tlip_pkg::SRC_EXT0]     = prioPri_q[0];
    srcHigh[tlip_pkg::SRC_ADC]      = prioPri_q[6];
    srcHigh[tlip_pkg::SRC_TIMER0]   = prioPri_q[1];
    srcHigh[tlip_pkg::SRC_EXT1]     = prioPri_q[2];
    srcHigh[tlip_pkg::SRC_TIMER1]   = prioPri_q[3];
    srcHigh[tlip_pkg::SRC_SPI]      = secCtrl_q[tlip_pkg::SEC_SPI_PRIO];
    srcHigh[tlip_pkg::SRC_UART]     = prioPri_q[4];
    srcHigh[tlip_pkg::SRC_TIMER2]   = prioPri_q[5];
    srcHigh[tlip_pkg::SRC_INTERVAL] = secCtrl_q[tlip_pkg::SEC_INTERVAL_PRIO];
  end

  // The global enable gates every source.
  assign pendHigh = mainEn_q[tlip_pkg::MAIN_GLOBAL_EN] ? (req_q & srcEn & srcHigh) : '0;
  assign pendLow  = mainEn_q[tlip_pkg::MAIN_GLOBAL_EN] ? (req_q & srcEn & ~srcHigh) : '0;

  // Watchdog sits at a lower index than external 0, so it is polled first.
  tlip_select #(.N(N)) selHigh (
    .req (pendHigh),
    .any (anyHigh),
    .idx (idxHigh)
  );

  tlip_select #(.N(N)) selLow (
    .req (pendLow),
    .any (anyLow),
    .idx (idxLow)
  );

  // High may interrupt low but not another high; low may interrupt nothing.
  assign canHigh = anyHigh && !highActive;
  assign canLow  = anyLow && !highActive && !lowActive;

  // Offer one vector at a time; high level wins when both are ready.
  always_ff @(posedge mclk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      vecValid_q <= 1'b0;
      vec_q      <= '0;
    end else if (clkEn) begin
      if (vecValid_q && vecAck) begin
        vecValid_q <= 1'b0;
      end else if (!vecValid_q && canHigh) begin
        vecValid_q <= 1'b1;
        vec_q      <= '{addr: vecOf(idxHigh), high: 1'b1, src: idxHigh};
      end else if (!vecValid_q && canLow) begin
        vecValid_q <= 1'b1;
        vec_q      <= '{addr: vecOf(idxLow), high: 1'b0, src: idxLow};
      end else if (vecValid_q && !vec_q.high && canHigh) begin
        // A late high request replaces a low vector not yet taken.
        vec_q <= '{addr: vecOf(idxHigh), high: 1'b1, src: idxHigh};
      end
    end
  end

  // The core pushes its program counter and jumps on acknowledge.
  assign vecReq   = vecValid_q;
  assign vecOut   = vec_q;
  assign takeHigh = vecValid_q && vecAck && vec_q.high;
  assign takeLow  = vecValid_q && vecAck && !vec_q.high;

  // A return releases the innermost active level.
  tlip_nest nest (
    .mclk       (mclk),
    .rstN       (rstSync_q),
    .clkEn      (clkEn),
    .takeLow    (takeLow),
    .takeHigh   (takeHigh),
    .retire     (retiDone),
    .lowActive  (lowActive),
    .highActive (highActive)
  );

  // Offered vector always matches its source's fixed address.
  chk_vec_matches: assert property (@(posedge mclk) disable iff (!rstSync_q)
    vecValid_q |-> vec_q.addr == vecOf(vec_q.src))
    else $error("vector address does not match source");

  // No vector is offered for a high request during a high routine.
  chk_no_same_high: assert property (@(posedge mclk) disable iff (!rstSync_q)
    (clkEn && highActive && !vecValid_q) |=> !vecValid_q || !vec_q.high)
    else $error("high vector offered inside high routine");

  // Global disable blocks new vectors.
  chk_global_off: assert property (@(posedge mclk) disable iff (!rstSync_q)
    (clkEn && !vecValid_q && !mainEn_q[7]) |=> !vecValid_q)
    else $error("vector offered with global enable off");

  // High pending with no high active leads to a high vector next.
  chk_high_first: assert property (@(posedge mclk) disable iff (!rstSync_q)
    (clkEn && !vecValid_q && canHigh) |=> vecValid_q && vec_q.high)
    else $error("high request not vectored first");

  // Accepting a high vector marks high active one cycle later.
  chk_high_nests: assert property (@(posedge mclk) disable iff (!rstSync_q)
    (clkEn && takeHigh) |=> highActive)
    else $error("high level not recorded");

  // Priority register reads back with reserved bit zero.
  chk_prio_rsvd: assert property (@(posedge mclk) disable iff (!rstSync_q)
    !prioPri_q[7])
    else $error("reserved priority bit set");

  // Secondary register bit 7 stays at its reset value.
  chk_sec_rsvd: assert property (@(posedge mclk) disable iff (!rstSync_q)
    secCtrl_q[7] == tlip_pkg::SEC_CTRL_RESET[7])
    else $error("secondary reserved bit changed");

  // A return with only low active clears low next cycle.
  chk_reti_release: assert property (@(posedge mclk) disable iff (!rstSync_q)
    (clkEn && retiDone && lowActive && !highActive && !vecAck) |=> !lowActive)
    else $error("return did not release level");

  // The core takes the offered vector in this cycle.
  sequence seqTake;
    clkEn && vecValid_q && vecAck;
  endsequence

  // A low routine runs alone and nothing is on offer yet.
  sequence seqLowOnly;
    clkEn && lowActive && !highActive && !vecValid_q;
  endsequence

  // Once taken, the offer is withdrawn, so one request never pushes twice in a row.
  chk_take_clears: assert property (@(posedge mclk) disable iff (!rstSync_q)
    seqTake |=> !vecValid_q)
    else $error("vector still offered after acceptance");

  // A low routine shuts out every other low request.
  chk_low_blocked: assert property (@(posedge mclk) disable iff (!rstSync_q)
    seqLowOnly |=> !vecValid_q || vec_q.high)
    else $error("low vector offered inside low routine");

  // A pending high request breaks into a low routine at the next edge.
  chk_high_preempts: assert property (@(posedge mclk) disable iff (!rstSync_q)
    (seqLowOnly and anyHigh) |=> vecValid_q && vec_q.high)
    else $error("high request did not preempt low routine");

endmodule
`default_nettype wire

//--- rtl/tlip_pkg.sv
// Package of constants and types for the two-level interrupt prioritizer.
package tlip_pkg;

  // Special function register addresses on the core's register port.
  localparam logic [7:0] MAIN_EN_ADDR   = 8'hA8;
  localparam logic [7:0] PRIO_PRI_ADDR  = 8'hB8;
  localparam logic [7:0] SEC_CTRL_ADDR  = 8'hA9;

  // Values after reset.
  localparam logic [7:0] MAIN_EN_RESET  = 8'h00;
  localparam logic [7:0] PRIO_PRI_RESET = 8'h00;
  localparam logic [7:0] SEC_CTRL_RESET = 8'hA0;

  // Field positions in the secondary control register.
  localparam int SEC_INTERVAL_PRIO = 6;
  localparam int SEC_SUPPLY_PRIO   = 5;
  localparam int SEC_SPI_PRIO      = 4;
  localparam int SEC_RSVD_ZERO     = 3;
  localparam int SEC_INTERVAL_EN   = 2;
  localparam int SEC_SUPPLY_EN     = 1;
  localparam int SEC_SPI_EN        = 0;

  // Field position of the global enable in the main enable register.
  localparam int MAIN_GLOBAL_EN    = 7;

  // Number of sources, counted in polling order.
  localparam int NUM_SRC = 11;

  // Source indices in polling order, index 0 polled first.
  localparam int SRC_SUPPLY   = 0;
  localparam int SRC_WATCHDOG = 1;
  localparam int SRC_EXT0     = 2;
  localparam int SRC_ADC      = 3;
  localparam int SRC_TIMER0   = 4;
  localparam int SRC_EXT1     = 5;
  localparam int SRC_TIMER1   = 6;
  localparam int SRC_SPI      = 7;
  localparam int SRC_UART     = 8;
  localparam int SRC_TIMER2   = 9;
  localparam int SRC_INTERVAL = 10;

  // Vector addresses, one per source.
  localparam logic [15:0] VEC_EXT0     = 16'h0003;
  localparam logic [15:0] VEC_TIMER0   = 16'h000B;
  localparam logic [15:0] VEC_EXT1     = 16'h0013;
  localparam logic [15:0] VEC_TIMER1   = 16'h001B;
  localparam logic [15:0] VEC_UART     = 16'h0023;
  localparam logic [15:0] VEC_TIMER2   = 16'h002B;
  localparam logic [15:0] VEC_ADC      = 16'h0033;
  localparam logic [15:0] VEC_SPI      = 16'h003B;
  localparam logic [15:0] VEC_SUPPLY   = 16'h0043;
  localparam logic [15:0] VEC_INTERVAL = 16'h0053;
  localparam logic [15:0] VEC_WATCHDOG = 16'h005B;

  // Register write or read request from the core.
  typedef struct packed {
    logic       wrEn;
    logic       rdEn;
    logic [7:0] addr;
    logic [7:0] wrData;
  } tlip_sfr_req_t;

  // Vector request handed to the core.
  typedef struct packed {
    logic [15:0] addr;
    logic        high;
    logic [3:0]  src;
  } tlip_vec_t;

endpackage

//--- rtl/tlip_select.sv
// Fixed-order selector that picks the first set bit of a request vector.
`timescale 1ns/10ps
`default_nettype none
module tlip_select #(
  parameter int N = 11
) (
  input  wire logic [N-1:0] req,
  output logic              any,
  output logic [3:0]        idx
);

  // The index port is four bits wide, so more than sixteen inputs cannot be served.
  initial begin
    if (N < 1 || N > 16) begin
      $error("tlip_select: N must lie between 1 and 16");
    end
  end

  // Scan from the highest index down so the lowest index wins last.
  always_comb begin
    any = |req;
    idx = 4'h0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        idx = i[3:0];
      end
    end
  end

endmodule
`default_nettype wire

//--- rtl/tlip_nest.sv
// Tracker of the active service levels for nesting control.
`timescale 1ns/10ps
`default_nettype none
module tlip_nest (
  input  wire logic mclk,
  input  wire logic rstN,
  input  wire logic clkEn,
  input  wire logic takeLow,
  input  wire logic takeHigh,
  input  wire logic retire,
  output logic      lowActive,
  output logic      highActive
);

  logic lowQ;  // A low-level routine is in progress.
  logic highQ; // A high-level routine is in progress.

  // A return retires the innermost level first; a high routine nests above a low one.
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      lowQ  <= 1'b0;
      highQ <= 1'b0;
    end else if (clkEn) begin
      if (takeHigh) begin
        highQ <= 1'b1;
      end else if (takeLow) begin
        lowQ <= 1'b1;
      end else if (retire) begin
        if (highQ) begin
          highQ <= 1'b0;
        end else begin
          lowQ <= 1'b0;
        end
      end
    end
  end

  assign lowActive  = lowQ;
  assign highActive = highQ;

endmodule
`default_nettype wire

//--- testbench/tlip_core_model.sv
// Behavioural processor core that takes vectors and returns from routines.
`timescale 1ns/10ps
`default_nettype none
module tlip_core_model (
  input  wire logic                mclk,
  input  wire logic                vecReq,
  input  wire tlip_pkg::tlip_vec_t vecOut,
  input  wire logic [1:0]          ackDelay,
  input  wire logic                retiCmd,
  output logic                     vecAck,
  output logic                     retiDone
);
  logic [15:0] pc;        // Program counter of the modelled core.
  logic [15:0] stack[$];  // Return addresses pushed on each accepted vector.
  logic [15:0] retPc;     // Address popped by the last return.
  int          waitN;     // Cycles spent so far before acknowledging.

  initial begin
    pc = 16'h0100;
    waitN = 0;
    vecAck = 1'b0;
    retiDone = 1'b0;
  end

  // Acknowledge after a chosen delay, so slow and prompt cores are both seen.
  always @(posedge mclk) begin
    if (vecReq && vecAck) begin
      stack.push_back(pc);
      pc <= vecOut.addr;
      vecAck <= 1'b0;
    end else if (vecReq && !vecAck) begin
      if (waitN >= int'(ackDelay)) begin
        vecAck <= 1'b1;
        waitN = 0;
      end else begin
        waitN++;
      end
    end
    // The program counter has this one writer, so a return only hands over its address.
    if (retiDone && !(vecReq && vecAck)) begin
      pc <= retPc;
    end
  end

  // A return is only issued for a vector really taken, once each.
  always @(posedge mclk) begin
    if (retiCmd && stack.size() > 0) begin
      retPc <= stack.pop_back();
      retiDone <= 1'b1;
    end else begin
      retiDone <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- testbench/testbench.sv
// Self-checking bench for the two-level interrupt prioritizer.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  // Enable bit of each source, in polling order; secondary ones marked below.
  localparam int EN_BIT[11] = '{1, 0, 0, 6, 1, 2, 3, 0, 4, 5, 2};
  localparam logic [10:0] IN_SEC = 11'b100_1000_0001;
  localparam logic [15:0] VEC[11] = '{16'h0043, 16'h005B, 16'h0003, 16'h0033,
    16'h000B, 16'h0013, 16'h001B, 16'h003B, 16'h0023, 16'h002B, 16'h0053};
  logic                    mclk, rst_n, clkEn, retiCmd, vecReq, vecAck;
  logic                    retiDone, lowActive, highActive, sfrHit, hi;
  logic [1:0]              ackDelay;
  logic [7:0]              sfrRdData;
  logic [10:0]             irq;
  tlip_pkg::tlip_sfr_req_t req;
  tlip_pkg::tlip_vec_t     vecOut;
  tlip_pkg::tlip_vec_t     expQ[$];  // Vectors the core should take, in order.
  int                      n_mismatch, samples_checked, cycles;

  tlip_top dut (.mclk(mclk), .rst_n(rst_n), .clkEn(clkEn), .sfrReq(req),
    .sfrRdData(sfrRdData), .sfrHit(sfrHit), .supply_mon_irq(irq[0]),
    .watchdog_irq(irq[1]), .ext0_irq(irq[2]), .adc_irq(irq[3]), .timer0_irq(irq[4]),
    .ext1_irq(irq[5]), .timer1_irq(irq[6]), .spi_i2c_irq(irq[7]), .uart_irq(irq[8]),
    .timer2_irq(irq[9]), .interval_irq(irq[10]), .vecReq(vecReq), .vecOut(vecOut),
    .vecAck(vecAck), .retiDone(retiDone), .lowActive(lowActive),
    .highActive(highActive));
  tlip_core_model core (.mclk(mclk), .vecReq(vecReq), .vecOut(vecOut),
    .ackDelay(ackDelay), .retiCmd(retiCmd), .vecAck(vecAck), .retiDone(retiDone));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // Counts one comparison and reports it at once if it differs.
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic conclude();
    $display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge mclk) req <= '{wrEn: 1'b1, rdEn: 1'b0, addr: a, wrData: d};
    @(posedge mclk) req <= '0;
  endtask

  // Read data is combinational, so it is looked at just after the edge.
  task automatic rd(logic [7:0] a, logic [7:0] d, logic hit);
    @(posedge mclk) req <= '{wrEn: 1'b0, rdEn: 1'b1, addr: a, wrData: 8'h00};
    #1;
    check("read data", {24'h0, d}, {24'h0, sfrRdData});
    check("read hit", {31'h0, hit}, {31'h0, sfrHit});
  endtask

  // Turns polling-order enable and level masks into the three registers.
  task automatic arm(logic [10:0] en, logic [10:0] pr, logic ea);
    logic [7:0] a8, b8, a9;
    a8 = {ea, 7'h00};
    b8 = 8'h00;
    a9 = 8'h00;  // Bit 3 always left at zero.
    for (int i = 0; i < 11; i++) begin
      if (IN_SEC[i]) begin
        a9[EN_BIT[i]] = en[i];
        a9[EN_BIT[i] + 4] = pr[i];
      end else if (i != 1) begin
        a8[EN_BIT[i]] = en[i];
        b8[EN_BIT[i]] = pr[i];
      end
    end
    // Main enable goes last, so nothing is offered before the expectation is queued.
    wr(8'hB8, b8);
    wr(8'hA9, a9);
    wr(8'hA8, a8);
  endtask

  task automatic reti();
    @(posedge mclk) retiCmd <= 1'b1;
    @(posedge mclk) retiCmd <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask

  // Expects source i at level h; the source drops its request once taken.
  task automatic service(int i, logic h, logic doReti);
    int n;
    n = 0;
    expQ.push_back('{addr: VEC[i], high: h, src: 4'(i)});
    ackDelay <= 2'($urandom % 4);
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (!(vecReq === 1'b1 && vecAck === 1'b1) && n < 200);
    check("vector taken", 1, {31'h0, n < 200});
    @(posedge mclk) irq[i] <= 1'b0;
    repeat (6) @(posedge mclk);
    if (doReti) reti();
  endtask

  task automatic quiet(int n);
    repeat (n) begin
      @(posedge mclk);
      #1;
      check("no vector", 0, {31'h0, vecReq});
    end
  endtask

  // Compares each vector at the edge where the core takes it.
  always @(posedge mclk) begin
    if (vecReq === 1'b1 && vecAck === 1'b1) begin
      if (expQ.size() == 0) check("unexpected vector", 0, 1);
      else check("vector", 32'(expQ.pop_front()), 32'(vecOut));
    end
  end

  // Cuts a hang short well beyond the expected run length.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      check("timeout", 0, 1);
      conclude();
    end
  end

  initial begin
    rst_n = 1'b0;
    clkEn = 1'b1;
    retiCmd = 1'b0;
    ackDelay = 2'h0;
    irq = '0;
    req = '0;
    void'($urandom(42905));
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    rd(8'hA8, 8'h00, 1'b1);
    rd(8'hB8, 8'h00, 1'b1);
    rd(8'hA9, 8'hA0, 1'b1);
    rd(8'hB9, 8'h00, 1'b0);
    wr(8'hB8, 8'hFF);
    wr(8'hB9, 8'h00);
    rd(8'hB8, 8'h7F, 1'b1);
    wr(8'hA9, 8'h77);
    rd(8'hA9, 8'hF7, 1'b1);
    // Each source alone at a random level; the watchdog is always low.
    for (int i = 0; i < 11; i++) begin
      hi = (i == 1) ? 1'b0 : 1'($urandom % 2);
      arm(11'h1 << i, {10'h0, hi} << i, 1'b1);
      irq[i] <= 1'b1;
      service(i, hi, 1'b1);
    end
    // With the global enable clear nothing is vectored.
    arm(11'h010, 11'h000, 1'b0);
    irq[4] <= 1'b1;
    quiet(12);
    // With the clock enable low a write is frozen out and nothing is offered.
    @(posedge mclk) clkEn <= 1'b0;
    arm(11'h010, 11'h000, 1'b1);
    quiet(8);
    rd(8'hA8, 8'h02, 1'b1);
    @(posedge mclk) clkEn <= 1'b1;
    arm(11'h010, 11'h000, 1'b1);
    service(4, 1'b0, 1'b1);
    // All sources together at one level come out in polling order.
    arm(11'h7FF, 11'h000, 1'b1);
    irq <= 11'h7FF;
    for (int i = 0; i < 11; i++) service(i, 1'b0, 1'b1);
    // A low routine is not interrupted by a low one, but is by a high one.
    arm(11'h114, 11'h100, 1'b1);
    irq[2] <= 1'b1;
    service(2, 1'b0, 1'b0);
    irq[4] <= 1'b1;
    quiet(12);
    check("low level", 1, {31'h0, lowActive});
    irq[8] <= 1'b1;
    service(8, 1'b1, 1'b1);
    check("high level", 0, {31'h0, highActive});
    check("low kept", 1, {31'h0, lowActive});
    quiet(8);
    reti();
    service(4, 1'b0, 1'b1);
    // Different levels raised together: the high one goes first.
    arm(11'h208, 11'h200, 1'b1);
    irq[3] <= 1'b1;
    irq[9] <= 1'b1;
    service(9, 1'b1, 1'b1);
    service(3, 1'b0, 1'b1);
    check("queue empty", 0, expQ.size());
    // A second reset in mid-run brings registers and levels back to their defaults.
    @(posedge mclk) rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    rd(8'hA9, 8'hA0, 1'b1);
    rd(8'hB8, 8'h00, 1'b1);
    rd(8'hA8, 8'h00, 1'b1);
    check("levels after reset", 0, {30'h0, lowActive, highActive});
    conclude();
  end
endmodule
`default_nettype wire
